// ==== src/core_irq_flags.sv ====
`timescale 1ns/1ps
module core_irq_flags
  import irq_flag_pkg::*;
#(
  parameter logic [DATA_W-1:0] PERIPH_PRESENT = 8'hff,
  parameter bit                EARLY_VARIANT  = 1'b0
) (
  // Clock and reset.
  input  wire logic              clk,
  input  wire logic              rst_n,
  // Register port.
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [DATA_W-1:0] wdata,
  input  wire logic              wr,
  input  wire logic              rd,
  output logic      [DATA_W-1:0] rdata,
  // Pins.
  input  wire logic              ext_irq_pin,
  input  wire logic [3:0]        second_gp_port,
  // Core side events.
  input  wire logic [7:0]        timer_zero_count,
  input  wire logic              port_read,
  input  wire logic [DATA_W-1:0] periph_event,
  input  wire logic              sleep_enter,
  input  wire logic              irq_ack,
  input  wire logic              return_from_irq_op,
  input  wire logic [PC_W-1:0]   return_pc,
  // Core side requests.
  output logic                   irq_request,
  output logic                   wake_up,
  output logic                   wake_to_vector,
  output logic                   stack_push,
  output logic      [PC_W-1:0]   stack_push_pc,
  output logic                   pc_load,
  output logic      [PC_W-1:0]   pc_load_value,
  output logic                   stack_pop,
  output logic                   global_irq_enable,
  output logic                   edge_polarity_select,
  output logic                   sleeping
);

  typedef struct packed {
    logic [DATA_W-1:0] ctrl;
    logic [DATA_W-1:0] option;
    logic [DATA_W-1:0] pflag;
    logic [DATA_W-1:0] pen;
    logic              pin_prev;
    logic [3:0]        port_prev;
    logic [3:0]        port_latch;
    logic [7:0]        timer_prev;
    core_mode_e        mode;
    logic [3:0]        sleep_arm;
    logic [DATA_W-1:0] rdata;
    logic              irq_request;
    logic              wake_up;
    logic              wake_to_vector;
    logic              stack_push;
    logic [PC_W-1:0]   stack_push_pc;
    logic              pc_load;
    logic [PC_W-1:0]   pc_load_value;
    logic              stack_pop;
  } state_s;

  state_s st_r;
  state_s st_nxt;

  logic       pin_s;
  logic [3:0] port_s;

  initial begin
    if (PC_W < 4) begin
      $error("Program counter too narrow for the vector.");
    end
    if (ADDR_W < 3) begin
      $error("Address too narrow for the core state register.");
    end
    if (DATA_W != 8) begin
      $error("Register width must be eight bits.");
    end
    if (CTRL_GLOBAL_BIT >= DATA_W) begin
      $error("Global enable lies outside the control register.");
    end
    if (OPT_EDGE_BIT >= DATA_W) begin
      $error("Polarity select lies outside the option register.");
    end
    if (PF_PARALLEL_BIT >= DATA_W) begin
      $error("Peripheral flag lies outside its register.");
    end
    if (CS_SLEEP_BIT >= DATA_W) begin
      $error("Sleep bit lies outside the core state register.");
    end
  end

  // Pins reach the detectors only after two flops.
  pin_sync #(.W(1)) u_pin_sync (
    .clk   (clk),
    .rst_n (rst_n),
    .d     (ext_irq_pin),
    .q     (pin_s)
  );

  pin_sync #(.W(4)) u_port_sync (
    .clk   (clk),
    .rst_n (rst_n),
    .d     (second_gp_port),
    .q     (port_s)
  );

  function automatic logic any_pending(input logic [DATA_W-1:0] c,
                                       input logic [DATA_W-1:0] pf,
                                       input logic [DATA_W-1:0] pe,
                                       input logic [3:0]        arm);
    logic ext_p;
    logic tmr_p;
    logic prt_p;
    logic per_p;
    ext_p = c[CTRL_EXT_FLAG_BIT] & c[CTRL_EXT_EN_BIT] & arm[0];
    tmr_p = c[CTRL_TIMER_FLAG_BIT] & c[CTRL_TIMER_EN_BIT] & arm[1];
    prt_p = c[CTRL_PORT_FLAG_BIT] & c[CTRL_PORT_EN_BIT] & arm[2];
    per_p = c[CTRL_PERIPH_EN_BIT] & arm[3] & (|(pf & pe));
    return ext_p | tmr_p | prt_p | per_p;
  endfunction

  // Unmapped offsets read as zero rather than aliasing a register.
  function automatic logic [DATA_W-1:0] reg_read(
      input logic [ADDR_W-1:0] a,
      input state_s            s);
    logic [DATA_W-1:0] v;
    v = '0;
    case (a)
      ADDR_IRQ_CTRL: begin
        v = s.ctrl;
      end
      ADDR_OPTION: begin
        v = s.option;
      end
      ADDR_PERIPH_FLAG: begin
        v = s.pflag;
      end
      ADDR_PERIPH_EN: begin
        v = s.pen;
      end
      ADDR_CORE_STATE: begin
        v[CS_SLEEP_BIT] = (s.mode == MODE_SLEEP);
      end
      default: begin
        v = '0;
      end
    endcase
    return v;
  endfunction

  always_comb begin
    logic              edge_hit;
    logic              wrap_hit;
    logic              change_hit;
    logic [DATA_W-1:0] pf_set;
    logic [3:0]        cur_en;
    edge_hit   = 1'b0;
    wrap_hit   = 1'b0;
    change_hit = 1'b0;
    pf_set     = '0;
    cur_en     = '0;
    st_nxt     = st_r;

    // Edge polarity picks which transition counts.
    if (st_r.option[OPT_EDGE_BIT]) begin
      edge_hit = pin_s & ~st_r.pin_prev;
    end else begin
      edge_hit = ~pin_s & st_r.pin_prev;
    end
    st_nxt.pin_prev = pin_s;

    wrap_hit = (st_r.timer_prev == TIMER_MAX) &&
               (timer_zero_count == TIMER_ZERO);
    st_nxt.timer_prev = timer_zero_count;

    // A mismatch against the read latch raises the flag every cycle it persists, except a read
    // cycle that sees the port change with EARLY_VARIANT set, so clearing the flag alone does not silence it.
    change_hit = (port_s != st_r.port_latch);
    if (port_read) begin
      st_nxt.port_latch = port_s;
      if (EARLY_VARIANT && (port_s != st_r.port_prev)) begin
        change_hit = 1'b0;
      end
    end
    st_nxt.port_prev = port_s;

    // Software writes first, so a hardware set in the same cycle wins.
    if (wr) begin
      case (addr)
        ADDR_IRQ_CTRL:    st_nxt.ctrl   = wdata;
        ADDR_OPTION:      st_nxt.option = wdata;
        ADDR_PERIPH_FLAG: st_nxt.pflag  = wdata & PERIPH_PRESENT;
        ADDR_PERIPH_EN:   st_nxt.pen    = wdata & PERIPH_PRESENT;
        default:          st_nxt.ctrl   = st_nxt.ctrl;
      endcase
    end

    // Flags set regardless of any enable.
    if (edge_hit) begin
      st_nxt.ctrl[CTRL_EXT_FLAG_BIT] = 1'b1;
    end
    if (wrap_hit) begin
      st_nxt.ctrl[CTRL_TIMER_FLAG_BIT] = 1'b1;
    end
    if (change_hit) begin
      st_nxt.ctrl[CTRL_PORT_FLAG_BIT] = 1'b1;
    end
    pf_set = periph_event & PERIPH_PRESENT;
    st_nxt.pflag = st_nxt.pflag | pf_set;

    // Entry and return own the global bit over a software write.
    st_nxt.stack_push = 1'b0;
    st_nxt.pc_load    = 1'b0;
    st_nxt.stack_pop  = 1'b0;
    if (irq_ack) begin
      st_nxt.ctrl[CTRL_GLOBAL_BIT] = 1'b0;
      st_nxt.stack_push    = 1'b1;
      st_nxt.stack_push_pc = return_pc;
      st_nxt.pc_load       = 1'b1;
      st_nxt.pc_load_value = VECTOR_ADDR;
    end else if (return_from_irq_op) begin
      st_nxt.ctrl[CTRL_GLOBAL_BIT] = 1'b1;
      st_nxt.stack_pop = 1'b1;
    end

    // Enables seen at sleep entry arm the wake sources.
    cur_en = {st_r.ctrl[CTRL_PERIPH_EN_BIT], st_r.ctrl[CTRL_PORT_EN_BIT],
              st_r.ctrl[CTRL_TIMER_EN_BIT], st_r.ctrl[CTRL_EXT_EN_BIT]};
    st_nxt.wake_up        = 1'b0;
    st_nxt.wake_to_vector = 1'b0;
    case (st_r.mode)
      MODE_RUN: begin
        if (sleep_enter) begin
          st_nxt.mode      = MODE_SLEEP;
          st_nxt.sleep_arm = cur_en;
        end
      end
      MODE_SLEEP: begin
        if (any_pending(st_r.ctrl, st_r.pflag, st_r.pen,
                        st_r.sleep_arm)) begin
          st_nxt.mode           = MODE_RUN;
          st_nxt.wake_up        = 1'b1;
          st_nxt.wake_to_vector = st_r.ctrl[CTRL_GLOBAL_BIT];
        end
      end
      default: st_nxt.mode = MODE_RUN;
    endcase

    st_nxt.irq_request = st_nxt.ctrl[CTRL_GLOBAL_BIT] &&
                         (st_nxt.mode == MODE_RUN) &&
                         any_pending(st_nxt.ctrl, st_nxt.pflag,
                                     st_nxt.pen, 4'hf);

    // Read data stand for exactly one cycle after the strobe.
    // Returning to zero keeps a stale value from looking like a fresh read.
    st_nxt.rdata = '0;
    if (rd) begin
      st_nxt.rdata = reg_read(addr, st_r);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r        <= '0;
      st_r.ctrl   <= CTRL_RESET;
      st_r.option <= OPTION_RESET;
      st_r.pflag  <= PERIPH_RESET;
      st_r.pen    <= PERIPH_RESET;
      st_r.mode   <= MODE_RUN;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign rdata                = st_r.rdata;
  assign irq_request          = st_r.irq_request;
  assign wake_up              = st_r.wake_up;
  assign wake_to_vector       = st_r.wake_to_vector;
  assign stack_push           = st_r.stack_push;
  assign stack_push_pc        = st_r.stack_push_pc;
  assign pc_load              = st_r.pc_load;
  assign pc_load_value        = st_r.pc_load_value;
  assign stack_pop            = st_r.stack_pop;
  assign global_irq_enable    = st_r.ctrl[CTRL_GLOBAL_BIT];
  assign edge_polarity_select = st_r.option[OPT_EDGE_BIT];
  assign sleeping             = (st_r.mode == MODE_SLEEP);

endmodule

// ==== shared/irq_flag_pkg.sv ====
package irq_flag_pkg;

  // Register bus geometry.
  localparam int ADDR_W = 3;
  localparam int DATA_W = 8;
  localparam int PC_W   = 13;

  // Register offsets.
  localparam logic [ADDR_W-1:0] ADDR_IRQ_CTRL    = 3'h0;
  localparam logic [ADDR_W-1:0] ADDR_OPTION      = 3'h1;
  localparam logic [ADDR_W-1:0] ADDR_PERIPH_FLAG = 3'h2;
  localparam logic [ADDR_W-1:0] ADDR_PERIPH_EN   = 3'h3;
  localparam logic [ADDR_W-1:0] ADDR_CORE_STATE  = 3'h4;

  // Field positions in irq_control_reg.
  localparam int CTRL_GLOBAL_BIT      = 7;
  localparam int CTRL_PERIPH_EN_BIT   = 6;
  localparam int CTRL_TIMER_EN_BIT    = 5;
  localparam int CTRL_EXT_EN_BIT      = 4;
  localparam int CTRL_PORT_EN_BIT     = 3;
  localparam int CTRL_TIMER_FLAG_BIT  = 2;
  localparam int CTRL_EXT_FLAG_BIT    = 1;
  localparam int CTRL_PORT_FLAG_BIT   = 0;

  // Field position in the option register.
  localparam int OPT_EDGE_BIT = 6;

  // Peripheral flag positions, same layout in the enable register.
  localparam int PF_PARALLEL_BIT = 7;
  localparam int PF_RECEIVE_BIT  = 6;
  localparam int PF_TRANSMIT_BIT = 5;
  localparam int PF_SYNC_BIT     = 4;
  localparam int PF_CAPT1_BIT    = 3;
  localparam int PF_TMR2_BIT     = 2;
  localparam int PF_TMR1_BIT     = 1;
  localparam int PF_CAPT2_BIT    = 0;

  // Core state register fields.
  localparam int CS_SLEEP_BIT = 0;

  // Values after reset.
  localparam logic [DATA_W-1:0] CTRL_RESET   = 8'h00;
  localparam logic [DATA_W-1:0] OPTION_RESET = 8'h00;
  localparam logic [DATA_W-1:0] PERIPH_RESET = 8'h00;

  // Timer wrap detection and vector.
  localparam logic [7:0]      TIMER_MAX   = 8'hff;
  localparam logic [7:0]      TIMER_ZERO  = 8'h00;
  localparam logic [PC_W-1:0] VECTOR_ADDR = 13'h0004;

  typedef enum logic {MODE_RUN, MODE_SLEEP} core_mode_e;

endpackage

// ==== src/pin_sync.sv ====
`timescale 1ns/1ps
module pin_sync
  import irq_flag_pkg::*;
#(
  parameter int W = 1
) (
  // Clock and reset.
  input  wire logic         clk,
  input  wire logic         rst_n,
  // Asynchronous level in, synchronised level out.
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } sync_s;

  sync_s st_r;
  sync_s st_nxt;

  initial begin
    if (W < 1) begin
      $error("pin_sync needs W of at least one.");
    end
  end

  // The first stage feeds only the second stage.
  always_comb begin
    st_nxt    = st_r;
    st_nxt.s1 = d;
    st_nxt.s2 = st_r.s1;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign q = st_r.s2;

endmodule

// ==== tb/irq_flag_sva.sv ====
`timescale 1ns/1ps
module irq_flag_sva
  import irq_flag_pkg::*;
(
  // Clock, reset and register writes.
  input wire logic              clk,
  input wire logic              rst_n,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] wdata,
  input wire logic              wr,
  // Events and core side.
  input wire logic              ext_irq_pin,
  input wire logic [7:0]        timer_zero_count,
  input wire logic              irq_ack,
  input wire logic              return_from_irq_op,
  input wire logic [PC_W-1:0]   return_pc,
  input wire logic              irq_request,
  input wire logic              wake_up,
  input wire logic              wake_to_vector,
  input wire logic              stack_push,
  input wire logic [PC_W-1:0]   stack_push_pc,
  input wire logic              pc_load,
  input wire logic [PC_W-1:0]   pc_load_value,
  input wire logic              stack_pop,
  input wire logic              global_irq_enable,
  input wire logic              edge_polarity_select,
  input wire logic              sleeping
);
  // Enables reach the ports only through writes, so they are mirrored.
  logic [3:0] en_r;
  logic       run;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) en_r <= 4'h0;
    else if (wr && addr == ADDR_IRQ_CTRL) en_r <= wdata[6:3];
  end
  assign run = global_irq_enable && !sleeping;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence pin_edge_s;
    edge_polarity_select ? $rose(ext_irq_pin) : $fell(ext_irq_pin);
  endsequence
  sequence wrap_s;
    $past(timer_zero_count) == TIMER_MAX && timer_zero_count == TIMER_ZERO;
  endsequence
  AST_EXT_EDGE: assert property (pin_edge_s ##0 en_r[1] |->
    ##[2:5] (irq_request || !run)) else $error("pin edge lost");
  AST_TIMER_WRAP: assert property (wrap_s ##0 en_r[2] |->
    ##[0:2] (irq_request || !run)) else $error("timer wrap lost");
  AST_GLOBAL_GATE: assert property (irq_request |-> run)
    else $error("request while globally off");
  AST_MASK: assert property (irq_request |-> en_r != 4'h0)
    else $error("request with all enables clear");
  AST_ENTRY: assert property (irq_ack |=> stack_push && pc_load
    && !global_irq_enable && pc_load_value == VECTOR_ADDR)
    else $error("bad interrupt entry");
  AST_SAVE_PC: assert property (irq_ack |=>
    stack_push_pc == $past(return_pc)) else $error("wrong saved pc");
  AST_RETURN: assert property (return_from_irq_op && !irq_ack |=>
    stack_pop && global_irq_enable) else $error("bad return");
  AST_WAKE: assert property (wake_up |-> $past(sleeping) &&
    !sleeping && wake_to_vector == global_irq_enable)
    else $error("bad wake");
endmodule

// ==== tb/core_seq_model.sv ====
`timescale 1ns/1ps
module core_seq_model
  import irq_flag_pkg::*;
(
  // Clock and reset.
  input  wire logic            clk,
  input  wire logic            rst_n,
  // Request in, entry out; lag slows the answer.
  input  wire logic            irq_request,
  input  wire logic            ack_on,
  input  wire logic [1:0]      lag,
  output logic                 irq_ack,
  output logic      [PC_W-1:0] return_pc
);
  logic [1:0] wait_r;
  // A request that drops while waiting is never served late.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wait_r    <= 2'h0;
      irq_ack   <= 1'b0;
      return_pc <= '0;
    end else begin
      irq_ack <= 1'b0;
      if (!irq_request || !ack_on || irq_ack) wait_r <= 2'h0;
      else if (wait_r != lag) wait_r <= wait_r + 2'h1;
      else begin
        irq_ack   <= 1'b1;
        return_pc <= return_pc + 13'h0101;
      end
    end
  end
endmodule

// ==== tb/core_interrupt_flag_logic_test.sv ====
`timescale 1ns/1ps
module core_interrupt_flag_logic_test
  import irq_flag_pkg::*;
;
  typedef struct packed {
    logic [ADDR_W-1:0] a;
    logic [DATA_W-1:0] d;
    logic [DATA_W-1:0] e;
  } row_s;
  // Absent peripheral bits and the unmapped hole must read back 0.
  row_s rows [6] = '{'{ADDR_IRQ_CTRL, 8'h78, 8'h78},
    '{ADDR_OPTION, 8'h40, 8'h40}, '{ADDR_PERIPH_EN, 8'h7e, 8'h7e},
    '{ADDR_PERIPH_FLAG, 8'h81, 8'h00}, '{3'h6, 8'h5a, 8'h00},
    '{ADDR_IRQ_CTRL, 8'h00, 8'h00}};
  logic              clk = 1'b0;
  logic              rst_n = 1'b0;
  logic [ADDR_W-1:0] addr = '0;
  logic [DATA_W-1:0] wdata = '0;
  logic              wr = 1'b0;
  logic              rd = 1'b0;
  logic              ext_irq_pin = 1'b0;
  logic [3:0]        second_gp_port = 4'h0;
  logic [7:0]        timer_zero_count = 8'h00;
  logic              port_read = 1'b0;
  logic [7:0]        periph_event = 8'h00;
  logic              sleep_enter = 1'b0;
  logic              return_from_irq_op = 1'b0;
  logic              ack_on = 1'b0;
  logic [1:0]        lag = 2'h2;
  logic [DATA_W-1:0] rdata;
  logic [PC_W-1:0]   return_pc, stack_push_pc, pc_load_value;
  logic              irq_ack, irq_request, wake_up, wake_to_vector;
  logic              stack_push, pc_load, stack_pop, sleeping;
  logic              global_irq_enable, edge_polarity_select;
  int                n_mismatch = 0;
  int                tests_run = 0;
  int                cycles = 0;
  int                i;
  core_irq_flags #(.PERIPH_PRESENT(8'h7e), .EARLY_VARIANT(1'b0))
    u_core_irq_flags (.clk, .rst_n, .addr, .wdata, .wr, .rd, .rdata,
    .ext_irq_pin, .second_gp_port, .timer_zero_count, .port_read,
    .periph_event, .sleep_enter, .irq_ack, .return_from_irq_op,
    .return_pc, .irq_request, .wake_up, .wake_to_vector, .stack_push,
    .stack_push_pc, .pc_load, .pc_load_value, .stack_pop,
    .global_irq_enable, .edge_polarity_select, .sleeping);
  core_seq_model u_core_seq_model (.clk, .rst_n, .irq_request, .ack_on,
    .lag, .irq_ack, .return_pc);
  initial begin
    forever #2.5 clk = ~clk;
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd_chk(input logic [2:0] a, input logic [7:0] e);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk(rdata, e);
    @(posedge clk);
  endtask
  task automatic pace;
    repeat (6) @(posedge clk);
  endtask
  task automatic test_done;
    $display("Mismatches %0d, comparisons %0d", n_mismatch, tests_run);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // The ceiling sits far above the roughly 150 cycles the run needs.
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      n_mismatch++;
      test_done();
    end
  end
  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rd_chk(ADDR_IRQ_CTRL, CTRL_RESET);
    foreach (rows[k]) begin
      wr_reg(rows[k].a, rows[k].d);
      rd_chk(rows[k].a, rows[k].e);
    end
    ext_irq_pin <= 1'b1;
    pace();
    rd_chk(ADDR_IRQ_CTRL, 8'h02);
    wr_reg(ADDR_OPTION, 8'h00);
    wr_reg(ADDR_IRQ_CTRL, 8'h00);
    ext_irq_pin <= 1'b0;
    pace();
    rd_chk(ADDR_IRQ_CTRL, 8'h02);
    wr_reg(ADDR_IRQ_CTRL, 8'h20);
    ext_irq_pin <= 1'b1;
    timer_zero_count <= 8'hff;
    @(posedge clk);
    timer_zero_count <= 8'h00;
    pace();
    rd_chk(ADDR_IRQ_CTRL, 8'h24);
    wr_reg(ADDR_IRQ_CTRL, 8'h08);
    second_gp_port <= 4'h5;
    pace();
    rd_chk(ADDR_IRQ_CTRL, 8'h09);
    port_read <= 1'b1;
    @(posedge clk);
    port_read <= 1'b0;
    wr_reg(ADDR_IRQ_CTRL, 8'h00);
    pace();
    rd_chk(ADDR_IRQ_CTRL, 8'h00);
    periph_event <= 8'hff;
    @(posedge clk);
    periph_event <= 8'h00;
    pace();
    rd_chk(ADDR_PERIPH_FLAG, 8'h7e);
    wr_reg(ADDR_PERIPH_FLAG, 8'h00);
    wr_reg(ADDR_IRQ_CTRL, 8'h80);
    ext_irq_pin <= 1'b0;
    ack_on <= 1'b1;
    pace();
    chk({7'h0, irq_request}, 8'h00);
    wr_reg(ADDR_IRQ_CTRL, 8'h92);
    for (i = 0; i < 12 && pc_load !== 1'b1; i++) @(posedge clk);
    chk({7'h0, pc_load}, 8'h01);
    rd_chk(ADDR_IRQ_CTRL, 8'h12);
    wr_reg(ADDR_IRQ_CTRL, 8'h10);
    return_from_irq_op <= 1'b1;
    @(posedge clk);
    return_from_irq_op <= 1'b0;
    @(posedge clk);
    chk({7'h0, stack_pop}, 8'h01);
    rd_chk(ADDR_IRQ_CTRL, 8'h90);
    wr_reg(ADDR_IRQ_CTRL, 8'h10);
    wr_reg(ADDR_OPTION, 8'h40);
    chk({7'h0, edge_polarity_select}, 8'h01);
    sleep_enter <= 1'b1;
    @(posedge clk);
    sleep_enter <= 1'b0;
    ext_irq_pin <= 1'b1;
    for (i = 0; i < 12 && wake_up !== 1'b1; i++) @(posedge clk);
    chk({6'h0, wake_up, wake_to_vector}, 8'h02);
    wr_reg(ADDR_IRQ_CTRL, 8'h00);
    wr_reg(ADDR_OPTION, 8'h00);
    chk({7'h0, edge_polarity_select}, 8'h00);
    sleep_enter <= 1'b1;
    @(posedge clk);
    sleep_enter <= 1'b0;
    ext_irq_pin <= 1'b0;
    pace();
    chk({7'h0, sleeping}, 8'h01);
    rd_chk(ADDR_IRQ_CTRL, 8'h02);
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rd_chk(ADDR_IRQ_CTRL, CTRL_RESET);
    test_done();
  end
endmodule
bind core_irq_flags irq_flag_sva u_irq_flag_sva (.clk, .rst_n, .addr,
  .wdata, .wr, .ext_irq_pin, .timer_zero_count, .irq_ack,
  .return_from_irq_op, .return_pc, .irq_request, .wake_up,
  .wake_to_vector, .stack_push, .stack_push_pc, .pc_load, .pc_load_value,
  .stack_pop, .global_irq_enable, .edge_polarity_select, .sleeping);
